// >>> ftal_logger.sv
// flow archive and triggered archive record logger with apb registers
// assumes samples, flow flags and clock ticks come from logic on CORE_CLK;
// archive storage lives outside and takes one word per WR_VALID pulse
//
// How it works
// - record size is 61, 31, 21 or 16
// - date, time, status fixed in every flow record
// - flow depth 6144 at 61, 24576 at 16
// - at most 58 user values per record
// - selection order kept, empty slots skipped
// - average, maximum or minimum over the interval
// - flow weighted values accumulate only while flowing
// - unweighted values span the whole interval
// - partial request honoured only when enabled
// - triggered records hold up to 19 registers
// - triggered logging as fast as once per second
// - triggered depth 135,000 to 1.35 million records
// - six triggered archive modes
// - log at each archive interval end
// - log at each minute or hour rollover
// - log at each contract period boundary
// - full log with wrap restarts at record zero
// - full log with stop discards further events
// - daily close at contract hour, oldest overwritten
// - maintenance entry and exit each close record
// - partial option on after reset, shared setting
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps

module ftal_logger
  import ftal_pkg::*;
#(
  parameter int NSLOT = 58,
  parameter int NTRIG = 19
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic        CLK_EN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SMP_VALID,
  input  wire logic [5:0]  SMP_SLOT,
  input  wire logic [31:0] SMP_DATA,
  input  wire logic        FLOW_RUN1,
  input  wire logic        FLOW_RUN2,
  input  wire logic [31:0] RTC_DATE,
  input  wire logic [31:0] RTC_TIME,
  input  wire logic        RTC_SEC_TICK,
  input  wire logic        RTC_MIN_TICK,
  input  wire logic        RTC_HOUR_TICK,
  input  wire logic        INTERVAL_END,
  input  wire logic        CONTRACT_HOUR,
  input  wire logic        ROLL_DAY,
  input  wire logic        ROLL_WEEK,
  input  wire logic        ROLL_MONTH,
  input  wire logic        ROLL_YEAR,
  input  wire logic        MAINT_MODE,
  input  wire logic        ALARM_ACT,
  input  wire logic        DIGIN_ACT,
  input  wire logic        PID_STEP,
  output logic             WR_VALID,
  output logic             WR_ARCH,
  output logic      [23:0] WR_ADDR,
  output logic      [31:0] WR_DATA,
  output logic             TRIG_FULL
);

  localparam int SW = 6;

  typedef struct packed {
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
    logic [1:0]                    size_sel;
    logic                          part_en;
    logic                          trig_wrap;
    ftal_mode_t                    trig_mode;
    ftal_rtp_t                     rtp_opt;
    logic [4:0]                    trig_n;
    logic [15:0]                   trig_per;
    logic [NSLOT-1:0]              slot_en;
    logic [NSLOT-1:0][1:0]         slot_fn;
    logic [NSLOT-1:0][1:0]         slot_wt;
    logic [NTRIG-1:0][SW-1:0]      trig_sel;
    logic [NSLOT-1:0][47:0]        acc;
    logic [NSLOT-1:0][23:0]        cnt;
    logic [NSLOT-1:0][31:0]        last;
    logic [23:0]                   flow_ptr;
    logic [23:0]                   trig_ptr;
    logic                          trig_full;
    logic [15:0]                   trig_lost;
    logic                          flow_pend;
    logic [2:0]                    reason;
    logic [3:0]                    rsn_cur;
    logic                          trig_pend;
    logic                          maint_q;
    logic                          alarm_q;
    logic                          din_q;
    logic [15:0]                   sec_cnt;
    ftal_state_t                   state;
    logic [SW-1:0]                 idx;
    logic [4:0]                    fld;
    logic [5:0]                    ucnt;
    logic                          wr_valid;
    logic                          wr_arch;
    logic [23:0]                   wr_addr;
    logic [31:0]                   wr_data;
  } ftal_regs_t;

  ftal_regs_t r_r;
  ftal_regs_t r_nxt;

  function automatic logic [5:0] rec_fields(input logic [1:0] sel);
    case (sel)
      2'h0:    rec_fields = FIELDS_61;
      2'h1:    rec_fields = FIELDS_31;
      2'h2:    rec_fields = FIELDS_21;
      default: rec_fields = FIELDS_16;
    endcase
  endfunction

  function automatic logic [23:0] flow_depth(input logic [1:0] sel);
    case (sel)
      2'h0:    flow_depth = DEPTH_61;
      2'h1:    flow_depth = DEPTH_31;
      2'h2:    flow_depth = DEPTH_21;
      default: flow_depth = DEPTH_16;
    endcase
  endfunction

  // deeper log for narrower records, never past the cap
  function automatic logic [23:0] trig_depth(input logic [4:0] n);
    logic [23:0] d;
    d = TRIG_SPACE / {19'h0, n};
    trig_depth = (d > TRIG_CAP) ? TRIG_CAP : d;
  endfunction

  // an empty interval stores zero rather than a stale value
  function automatic logic [31:0] reduce(input logic [1:0] fn, input logic [47:0] acc,
                                         input logic [23:0] cnt);
    logic [47:0] q;
    q = 48'h0;
    if (cnt == 24'h0) begin
      reduce = 32'h0;
    end else if (fn == FN_AVG) begin
      q = 48'($signed(acc) / $signed({24'h0, cnt}));
      reduce = q[31:0];
    end else begin
      reduce = acc[31:0];
    end
  endfunction

  logic [5:0]    fields;
  logic [23:0]   fbase;
  logic [23:0]   tbase;
  logic          setup;
  logic          wr_go;
  logic          hit;
  logic [31:0]   rdat;
  logic [5:0]    ri;
  logic          trig_ev;
  logic          rtp_hit;
  logic          flow_ok;
  logic [SW-1:0] s;
  logic [4:0]    tn;

  always_comb begin
    r_nxt    = r_r;
    fields   = rec_fields(r_r.size_sel);
    fbase    = r_r.flow_ptr * {18'h0, fields};
    tbase    = r_r.trig_ptr * {19'h0, r_r.trig_n};
    setup    = PSEL && !PENABLE;
    wr_go    = PSEL && PENABLE && r_r.pready && PWRITE;
    ri       = PADDR[7:2];
    hit      = 1'b0;
    rdat     = 32'h0;
    trig_ev  = 1'b0;
    rtp_hit  = 1'b0;
    flow_ok  = 1'b0;
    s        = SMP_SLOT;
    tn       = 5'h0;
    r_nxt.wr_valid = 1'b0;
    r_nxt.pready   = 1'b0;

    // address decode shared by setup read and access write
    case (PADDR[11:8])
      REG_CORE: begin
        hit = (PADDR[1:0] == 2'h0) && (PADDR[7:0] <= OFS_TRIG_LOST);
        case (PADDR[7:0])
          OFS_CTRL: rdat = {11'h0, r_r.trig_n, 5'h0, r_r.rtp_opt, 1'b0, r_r.trig_mode,
                            r_r.trig_wrap, r_r.part_en, r_r.size_sel};
          OFS_TRIG_PER:   rdat = {16'h0, r_r.trig_per};
          OFS_STATUS:     rdat = {28'h0, r_r.trig_full, r_r.trig_pend, r_r.flow_pend,
                                  r_r.state != S_IDLE};
          OFS_FLOW_PTR:   rdat = {8'h0, r_r.flow_ptr};
          OFS_TRIG_PTR:   rdat = {8'h0, r_r.trig_ptr};
          OFS_FLOW_DEPTH: rdat = {8'h0, flow_depth(r_r.size_sel)};
          OFS_TRIG_DEPTH: rdat = {8'h0, trig_depth(r_r.trig_n)};
          OFS_TRIG_LOST:  rdat = {16'h0, r_r.trig_lost};
          default:        rdat = 32'h0;
        endcase
      end
      REG_SLOT: begin
        hit = {26'h0, ri} < NSLOT;
        if (hit) begin
          rdat = {27'h0, r_r.slot_wt[ri], r_r.slot_fn[ri], r_r.slot_en[ri]};
        end
      end
      REG_TSEL: begin
        hit = {26'h0, ri} < NTRIG;
        if (hit) begin
          rdat = {26'h0, r_r.trig_sel[ri]};
        end
      end
      default: hit = 1'b0;
    endcase

    // zero-wait slave: ready in the cycle after setup
    if (setup) begin
      r_nxt.pready  = 1'b1;
      r_nxt.pslverr = !hit;
      r_nxt.prdata  = (hit && !PWRITE) ? rdat : 32'h0;
    end

    // record writer; pending flags cleared here, events below set them again
    case (r_r.state)
      S_IDLE: begin
        if (r_r.flow_pend) begin
          r_nxt.flow_pend = 1'b0;
          r_nxt.rsn_cur   = {r_r.maint_q, r_r.reason};
          r_nxt.reason    = 3'h0;
          r_nxt.fld       = 5'h0;
          r_nxt.state     = S_FHDR;
        end else if (r_r.trig_pend) begin
          r_nxt.trig_pend = 1'b0;
          // an event merged just before the log filled must not overwrite the last record
          if (r_r.trig_full) begin
            r_nxt.trig_lost = r_r.trig_lost + 16'h1;
          end else begin
            r_nxt.fld   = 5'h0;
            r_nxt.state = S_TFLD;
          end
        end
      end
      S_FHDR: begin
        r_nxt.wr_valid = 1'b1;
        r_nxt.wr_arch  = 1'b0;
        r_nxt.wr_addr  = fbase + {19'h0, r_r.fld};
        case (r_r.fld)
          5'h0:    r_nxt.wr_data = RTC_DATE;
          5'h1:    r_nxt.wr_data = RTC_TIME;
          default: r_nxt.wr_data = {28'h0, r_r.rsn_cur};
        endcase
        r_nxt.fld = r_r.fld + 5'h1;
        if (r_r.fld == 5'h2) begin
          r_nxt.idx   = '0;
          r_nxt.ucnt  = 6'h0;
          r_nxt.state = S_FSLOT;
        end
      end
      S_FSLOT: begin
        // one slot per cycle, in selection order; unselected ones emit nothing
        if (r_r.slot_en[r_r.idx] && (r_r.ucnt < fields - FIXED_FIELDS)) begin
          r_nxt.wr_valid = 1'b1;
          r_nxt.wr_arch  = 1'b0;
          r_nxt.wr_addr  = fbase + {18'h0, FIXED_FIELDS} + {18'h0, r_r.ucnt};
          r_nxt.wr_data  = reduce(r_r.slot_fn[r_r.idx], r_r.acc[r_r.idx],
                                  r_r.cnt[r_r.idx]);
          r_nxt.ucnt     = r_r.ucnt + 6'h1;
        end
        r_nxt.acc[r_r.idx] = 48'h0;
        r_nxt.cnt[r_r.idx] = 24'h0;
        r_nxt.idx = r_r.idx + 1'b1;
        if (r_r.idx == SW'(NSLOT - 1)) begin
          // the newest record overwrites the oldest once full
          if (r_r.flow_ptr == flow_depth(r_r.size_sel) - 24'h1) begin
            r_nxt.flow_ptr = 24'h0;
          end else begin
            r_nxt.flow_ptr = r_r.flow_ptr + 24'h1;
          end
          r_nxt.state = S_IDLE;
        end
      end
      S_TFLD: begin
        r_nxt.wr_valid = 1'b1;
        r_nxt.wr_arch  = 1'b1;
        r_nxt.wr_addr  = tbase + {19'h0, r_r.fld};
        r_nxt.wr_data  = r_r.last[r_r.trig_sel[r_r.fld]];
        r_nxt.fld      = r_r.fld + 5'h1;
        if (r_r.fld == r_r.trig_n - 5'h1) begin
          if (r_r.trig_ptr == trig_depth(r_r.trig_n) - 24'h1) begin
            if (r_r.trig_wrap) begin
              r_nxt.trig_ptr = 24'h0;
            end else begin
              r_nxt.trig_full = 1'b1;
            end
          end else begin
            r_nxt.trig_ptr = r_r.trig_ptr + 24'h1;
          end
          r_nxt.state = S_IDLE;
        end
      end
      default: r_nxt.state = S_IDLE;
    endcase

    // register writes take effect at the completing edge only
    if (wr_go && hit) begin
      case (PADDR[11:8])
        REG_CORE: begin
          if (PADDR[7:0] == OFS_CTRL) begin
            r_nxt.size_sel  = PWDATA[CTRL_SIZE_LSB +: 2];
            r_nxt.part_en   = PWDATA[CTRL_PART_BIT];
            r_nxt.trig_wrap = PWDATA[CTRL_WRAP_BIT];
            r_nxt.trig_mode = ftal_mode_t'(PWDATA[CTRL_MODE_LSB +: 3]);
            r_nxt.rtp_opt   = ftal_rtp_t'(PWDATA[CTRL_RTP_LSB +: 3]);
            tn = PWDATA[CTRL_TN_LSB +: 5];
            r_nxt.trig_n = (tn == 5'h0) ? 5'h1 : ((tn > TRIG_MAX_N) ? TRIG_MAX_N : tn);
          end
          if (PADDR[7:0] == OFS_TRIG_PER) begin
            r_nxt.trig_per = PWDATA[15:0];
          end
          if (PADDR[7:0] == OFS_CMD) begin
            if (PWDATA[CMD_PARTIAL] && r_r.part_en) begin
              r_nxt.flow_pend = 1'b1;
              r_nxt.reason[RSN_PARTIAL] = 1'b1;
            end
            if (PWDATA[CMD_MANUAL] && r_r.trig_mode == TM_MANUAL) begin
              trig_ev = 1'b1;
            end
            // clearing the log keeps a record still pending; it is written from record zero
            if (PWDATA[CMD_TRIG_CLR]) begin
              r_nxt.trig_ptr  = 24'h0;
              r_nxt.trig_full = r_nxt.trig_full && !r_r.trig_full;
              r_nxt.trig_lost = 16'h0;
            end
          end
        end
        REG_SLOT: begin
          r_nxt.slot_en[ri] = PWDATA[SLOT_EN_BIT];
          r_nxt.slot_fn[ri] = PWDATA[SLOT_FN_LSB +: 2];
          r_nxt.slot_wt[ri] = PWDATA[SLOT_WT_LSB +: 2];
        end
        default: r_nxt.trig_sel[ri] = PWDATA[SW-1:0];
      endcase
    end

    // flow record closes; set wins over the writer's clear
    if (INTERVAL_END) begin
      r_nxt.flow_pend = 1'b1;
      r_nxt.reason[RSN_INTERVAL] = 1'b1;
    end
    if (CONTRACT_HOUR) begin
      r_nxt.flow_pend = 1'b1;
      r_nxt.reason[RSN_DAILY] = 1'b1;
    end
    r_nxt.maint_q = MAINT_MODE;
    if ((MAINT_MODE != r_r.maint_q) && r_r.part_en) begin
      r_nxt.flow_pend = 1'b1;
      r_nxt.reason[RSN_PARTIAL] = 1'b1;
    end

    // triggered archive events
    case (r_r.rtp_opt)
      RP_INTERVAL: rtp_hit = INTERVAL_END;
      RP_MINUTE:   rtp_hit = RTC_MIN_TICK;
      RP_HOUR:     rtp_hit = RTC_HOUR_TICK;
      RP_DAY:      rtp_hit = ROLL_DAY;
      RP_WEEK:     rtp_hit = ROLL_WEEK;
      RP_MONTH:    rtp_hit = ROLL_MONTH;
      RP_YEAR:     rtp_hit = ROLL_YEAR;
      default:     rtp_hit = 1'b0;
    endcase
    r_nxt.alarm_q = ALARM_ACT;
    r_nxt.din_q   = DIGIN_ACT;
    // a zero period runs at the one-second floor
    if (RTC_SEC_TICK) begin
      if ({16'h0, r_r.sec_cnt} + 32'h1 >= {16'h0, r_r.trig_per}) begin
        r_nxt.sec_cnt = 16'h0;
        if (r_r.trig_mode == TM_PERIODIC) begin
          trig_ev = 1'b1;
        end
      end else begin
        r_nxt.sec_cnt = r_r.sec_cnt + 16'h1;
      end
    end
    case (r_r.trig_mode)
      TM_RTP:   trig_ev = trig_ev | rtp_hit;
      TM_ALARM: trig_ev = trig_ev | (ALARM_ACT && !r_r.alarm_q);
      TM_DIGIN: trig_ev = trig_ev | (DIGIN_ACT && !r_r.din_q);
      TM_PID:   trig_ev = trig_ev | PID_STEP;
      default:  trig_ev = trig_ev;
    endcase
    // an event already pending merges; a full stopped log drops it
    if (trig_ev) begin
      if (r_nxt.trig_full && !r_r.trig_wrap) begin
        r_nxt.trig_lost = r_nxt.trig_lost + 16'h1;
      end else begin
        r_nxt.trig_pend = 1'b1;
      end
    end

    // sample accumulation, after the writer may have restarted the slot
    if (SMP_VALID && ({26'h0, s} < NSLOT)) begin
      r_nxt.last[s] = SMP_DATA;
      case (r_r.slot_wt[s])
        WT_RUN1: flow_ok = FLOW_RUN1;
        WT_RUN2: flow_ok = FLOW_RUN2;
        default: flow_ok = 1'b1;
      endcase
      if (r_r.slot_en[s] && flow_ok) begin
        r_nxt.cnt[s] = r_nxt.cnt[s] + 24'h1;
        case (r_r.slot_fn[s])
          FN_AVG: r_nxt.acc[s] = r_nxt.acc[s] + {{16{SMP_DATA[31]}}, SMP_DATA};
          FN_MAX: begin
            if (r_nxt.cnt[s] == 24'h1 || $signed(SMP_DATA) > $signed(r_nxt.acc[s][31:0])) begin
              r_nxt.acc[s] = {{16{SMP_DATA[31]}}, SMP_DATA};
            end
          end
          FN_MIN: begin
            if (r_nxt.cnt[s] == 24'h1 || $signed(SMP_DATA) < $signed(r_nxt.acc[s][31:0])) begin
              r_nxt.acc[s] = {{16{SMP_DATA[31]}}, SMP_DATA};
            end
          end
          default: r_nxt.acc[s] = {{16{SMP_DATA[31]}}, SMP_DATA};
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      r_r           <= '0;
      r_r.size_sel  <= RST_SIZE;
      r_r.part_en   <= RST_PART_EN;
      r_r.trig_wrap <= RST_WRAP;
      r_r.trig_n    <= RST_TRIG_N;
      r_r.trig_per  <= RST_TRIG_PER;
      r_r.trig_mode <= TM_RTP;
      r_r.rtp_opt   <= RP_INTERVAL;
      r_r.state     <= S_IDLE;
    end else if (CLK_EN) begin
      r_r <= r_nxt;
    end
  end

  assign PRDATA    = r_r.prdata;
  assign PREADY    = r_r.pready;
  assign PSLVERR   = r_r.pslverr;
  assign WR_VALID  = r_r.wr_valid;
  assign WR_ARCH   = r_r.wr_arch;
  assign WR_ADDR   = r_r.wr_addr;
  assign WR_DATA   = r_r.wr_data;
  assign TRIG_FULL = r_r.trig_full;

endmodule

// >>> ftal_logger_sva.sv
// concurrent checks on the logger ports
// assumes CLK_EN high and a single core clock
`timescale 1ns/1ps

module ftal_sva (
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  input wire logic        CLK_EN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [31:0] RTC_DATE,
  input wire logic [31:0] RTC_TIME,
  input wire logic        CONTRACT_HOUR,
  input wire logic        WR_VALID,
  input wire logic        WR_ARCH,
  input wire logic [23:0] WR_ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic        TRIG_FULL
);
  logic fw;
  logic tw;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  assign fw = WR_VALID && !WR_ARCH;
  assign tw = WR_VALID && WR_ARCH;

  apb_ready_a: assert property (PSEL && !PENABLE && CLK_EN |=> PREADY)
    else $error("ready missing");
  ready_phase_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  err_zero_a: assert property (PREADY && PSLVERR |-> PRDATA == 32'h00000000)
    else $error("error read not zero");
  // date word opens a record, time follows at once
  flow_hdr_a: assert property (fw && !$past(fw) && WR_DATA == RTC_DATE
    |=> fw && WR_DATA == RTC_TIME ##1 fw) else $error("bad record header");
  flow_step_a: assert property (fw && $past(fw) |-> WR_ADDR == $past(WR_ADDR) + 24'h000001)
    else $error("flow address skipped");
  trig_step_a: assert property (tw && $past(tw) |-> WR_ADDR == $past(WR_ADDR) + 24'h000001)
    else $error("trig address skipped");
  full_stop_a: assert property ($past(TRIG_FULL) |-> !tw)
    else $error("write while full");
  day_close_a: assert property (CONTRACT_HOUR && CLK_EN |-> ##[1:200] fw)
    else $error("daily record missing");
endmodule

bind ftal_logger ftal_sva chk (.CORE_CLK(CORE_CLK), .RESET(RESET), .CLK_EN(CLK_EN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .RTC_DATE(RTC_DATE), .RTC_TIME(RTC_TIME), .CONTRACT_HOUR(CONTRACT_HOUR),
  .WR_VALID(WR_VALID), .WR_ARCH(WR_ARCH), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
  .TRIG_FULL(TRIG_FULL));

// >>> ftal_logger_tb.sv
// self-checking bench for the archive logger
// assumes package, logger and checker compiled first
`timescale 1ns/1ps

`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end

module ftal_logger_tb
  import ftal_pkg::*;
;
  // arbitrary stamp values
  localparam logic [31:0] DT_W = 32'h00A5C3D1;
  localparam logic [31:0] TM_W = 32'h0000B7E2;
  logic        clk, rst, ce, psel, pen, pwr, sv, wv, wa, prdy, perr, er, tf, mm;
  logic [1:0]  run;
  logic [5:0]  ev, tk, ss;
  logic [11:0] paddr;
  logic [23:0] wad;
  logic [31:0] pwd, prd, sd, wd, rd, p;
  logic [31:0] fq [$];
  int          errors, checks, cyc, nt, n0;

  ftal_logger uut (
    .CORE_CLK(clk), .RESET(rst), .CLK_EN(ce), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .SMP_VALID(sv), .SMP_SLOT(ss), .SMP_DATA(sd),
    .FLOW_RUN1(run[0]), .FLOW_RUN2(run[1]), .RTC_DATE(DT_W), .RTC_TIME(TM_W),
    .RTC_SEC_TICK(ev[1]), .RTC_MIN_TICK(tk[0]), .RTC_HOUR_TICK(tk[1]),
    .INTERVAL_END(ev[0]), .CONTRACT_HOUR(ev[4]), .ROLL_DAY(tk[2]), .ROLL_WEEK(tk[3]),
    .ROLL_MONTH(tk[4]), .ROLL_YEAR(tk[5]), .MAINT_MODE(mm), .ALARM_ACT(ev[2]),
    .DIGIN_ACT(ev[3]), .PID_STEP(ev[5]), .WR_VALID(wv), .WR_ARCH(wa),
    .WR_ADDR(wad), .WR_DATA(wd), .TRIG_FULL(tf));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // capture every flow word, count triggered words
  always @(posedge clk) begin
    cyc++;
    if (wv === 1'b1 && wa === 1'b0) fq.push_back(wd);
    if (wv === 1'b1 && wa === 1'b1) nt++;
    if (cyc == 40000) begin
      errors++;
      final_report();
    end
  end

  task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk) pen <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
    if (n >= 20) errors++;
  endtask

  // poll status until nothing busy or pending
  task automatic idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    do begin
      ap(0, 12'h00C, 0);
      n++;
    end while (rd[2:0] !== 3'h0 && n < 60);
    if (n >= 60) errors++;
  endtask

  task automatic pulse(input int b);
    ev <= 6'h01 << b;
    @(posedge clk) ev <= 6'h00;
  endtask

  task automatic smp(input logic [5:0] s, input logic [31:0] d);
    sv <= 1;
    ss <= s;
    sd <= d;
    @(posedge clk) sv <= 0;
    @(posedge clk);
  endtask

  task automatic t_regs();
    logic [23:0] dp [4];
    dp = '{DEPTH_61, DEPTH_31, DEPTH_21, DEPTH_16};
    ap(0, 12'h000, 0);
    `CK("ctrl", 32'h0001000C, rd)
    ap(0, 12'h0FC, 0);
    `CK("slverr", 1'b1, er)
    for (int i = 0; i < 4; i++) begin
      ap(1, 12'h000, 32'h0001000C | i);
      ap(0, 12'h018, 0);
      `CK("depth", {8'h00, dp[i]}, rd)
    end
    // count above 19 clamps to 19
    ap(1, 12'h000, 32'h0019000C);
    ap(0, 12'h01C, 0);
    `CK("tdepth", 32'h00020F58, rd)
    ap(1, 12'h000, 32'h0001000C);
    $display("t_regs done");
  endtask

  task automatic t_flow();
    ap(1, 12'h100, 32'h00000009);
    ap(1, 12'h108, 32'h00000003);
    ap(1, 12'h10C, 32'h00000005);
    ap(0, 12'h010, 0);
    p = rd;
    run <= 2'b01;
    smp(0, 4);
    smp(2, 3);
    smp(3, 5);
    run <= 2'b10;
    smp(0, 100);
    smp(2, 9);
    smp(3, 2);
    fq.delete();
    n0 = nt;
    pulse(0);
    idle();
    `CK("flds", 6, fq.size())
    `CK("date", DT_W, fq[0])
    `CK("time", TM_W, fq[1])
    `CK("stat", 32'h1, fq[2])
    `CK("wavg", 32'h4, fq[3])
    `CK("max", 32'h9, fq[4])
    `CK("min", 32'h2, fq[5])
    `CK("trig", 1, nt - n0)
    ap(0, 12'h010, 0);
    `CK("ptr", p + 1, rd)
    fq.delete();
    pulse(4);
    idle();
    `CK("daily", 32'h2, fq[2])
    `CK("clear", 32'h0, fq[4])
    for (int i = 0; i < 58; i++)
      ap(1, 12'(12'h100 + 4 * i), 32'h1);
    fq.delete();
    pulse(0);
    idle();
    `CK("full61", 61, fq.size())
    $display("t_flow done");
  endtask

  task automatic t_part();
    fq.delete();
    ap(1, 12'h008, 32'h1);
    idle();
    `CK("part", 32'h4, fq[2])
    ap(1, 12'h000, 32'h00010008);
    fq.delete();
    ap(1, 12'h008, 32'h1);
    idle();
    `CK("ignored", 0, fq.size())
    ap(1, 12'h000, 32'h0001000C);
    fq.delete();
    mm <= 1;
    idle();
    mm <= 0;
    idle();
    `CK("maint", 122, fq.size())
    // an interval end seen while the enable is low must leave no record
    fq.delete();
    ce <= 0;
    pulse(0);
    ce <= 1;
    idle();
    `CK("frozen", 0, fq.size())
    $display("t_part done");
  endtask

  task automatic t_modes();
    for (int m = 0; m < 6; m++) begin
      ap(1, 12'h000, 32'h0001000C | (m << 4));
      n0 = nt;
      if (m == 4)
        ap(1, 12'h008, 32'h2);
      else
        pulse(m);
      idle();
      `CK("mode", 1, nt - n0)
    end
    // chosen tick logs, the neighbour tick must not
    for (int o = 1; o < 7; o++) begin
      ap(1, 12'h000, 32'h0001000C | (o << 8));
      n0 = nt;
      tk <= 6'h01 << (o - 1);
      @(posedge clk) tk <= 6'h01 << (o % 6);
      @(posedge clk) tk <= 6'h00;
      idle();
      `CK("rtp", 1, nt - n0)
    end
    ap(1, 12'h000, 32'h0013004C);
    n0 = nt;
    ap(1, 12'h008, 32'h2);
    idle();
    `CK("regs19", 19, nt - n0)
    // fifteen triggered records so far, none of them near the end of space
    ap(0, 12'h014, 0);
    `CK("tptr", 32'h0000000F, rd)
    ap(1, 12'h008, 32'h4);
    ap(0, 12'h014, 0);
    `CK("tclr", 32'h00000000, rd)
    `CK("tfull", 1'b0, tf)
    $display("t_modes done");
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    {psel, pen, pwr, sv, mm, run, ev, tk, ss, paddr, pwd, sd} = '0;
    ce = 1;
    rst = 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs();
    t_flow();
    t_part();
    t_modes();
    final_report();
  end
endmodule

// >>> ftal_pkg.sv
// shared constants for the flow and triggered archive logger
// assumes a 32-bit apb master and one 100 MHz core clock
package ftal_pkg;

  // apb register byte offsets (core region, paddr[11:8] == 0)
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_TRIG_PER   = 8'h04;
  localparam logic [7:0] OFS_CMD        = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h0C;
  localparam logic [7:0] OFS_FLOW_PTR   = 8'h10;
  localparam logic [7:0] OFS_TRIG_PTR   = 8'h14;
  localparam logic [7:0] OFS_FLOW_DEPTH = 8'h18;
  localparam logic [7:0] OFS_TRIG_DEPTH = 8'h1C;
  localparam logic [7:0] OFS_TRIG_LOST  = 8'h20;
  // regions selected by paddr[11:8]
  localparam logic [3:0] REG_CORE = 4'h0;
  localparam logic [3:0] REG_SLOT = 4'h1;
  localparam logic [3:0] REG_TSEL = 4'h2;

  // ctrl field positions
  localparam int CTRL_SIZE_LSB = 0;
  localparam int CTRL_PART_BIT = 2;
  localparam int CTRL_WRAP_BIT = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_RTP_LSB  = 8;
  localparam int CTRL_TN_LSB   = 16;
  // cmd bits
  localparam int CMD_PARTIAL   = 0;
  localparam int CMD_MANUAL    = 1;
  localparam int CMD_TRIG_CLR  = 2;
  // slot config field positions
  localparam int SLOT_EN_BIT   = 0;
  localparam int SLOT_FN_LSB   = 1;
  localparam int SLOT_WT_LSB   = 3;

  // reset values
  localparam logic [1:0]  RST_SIZE     = 2'h0;
  localparam logic        RST_PART_EN  = 1'b1;
  localparam logic        RST_WRAP     = 1'b1;
  localparam logic [4:0]  RST_TRIG_N   = 5'h01;
  localparam logic [15:0] RST_TRIG_PER = 16'h0001;

  // record sizes: 61, 31, 21, 16 fields, three of them fixed
  localparam logic [5:0]  FIELDS_61 = 6'h3D;
  localparam logic [5:0]  FIELDS_31 = 6'h1F;
  localparam logic [5:0]  FIELDS_21 = 6'h15;
  localparam logic [5:0]  FIELDS_16 = 6'h10;
  localparam logic [5:0]  FIXED_FIELDS = 6'h03;
  // flow archive depth per record size
  localparam logic [23:0] DEPTH_61 = 24'h001800;
  localparam logic [23:0] DEPTH_31 = 24'h003000;
  localparam logic [23:0] DEPTH_21 = 24'h004000;
  localparam logic [23:0] DEPTH_16 = 24'h006000;
  // triggered space: 135,000 records of 19, capped at 1.35 million
  localparam logic [23:0] TRIG_SPACE = 24'h272388;
  localparam logic [23:0] TRIG_CAP   = 24'h149970;
  localparam logic [4:0]  TRIG_MAX_N = 5'h13;

  // status field bits of a flow record
  localparam int RSN_INTERVAL = 0;
  localparam int RSN_DAILY    = 1;
  localparam int RSN_PARTIAL  = 2;
  localparam int RSN_MAINT    = 3;

  typedef enum logic [1:0] {FN_AVG, FN_MAX, FN_MIN, FN_DEVICE} ftal_fn_t;
  typedef enum logic [1:0] {WT_NONE, WT_RUN1, WT_RUN2, WT_RSVD} ftal_wt_t;
  typedef enum logic [2:0] {
    TM_RTP, TM_PERIODIC, TM_ALARM, TM_DIGIN, TM_MANUAL, TM_PID
  } ftal_mode_t;
  typedef enum logic [2:0] {
    RP_INTERVAL, RP_MINUTE, RP_HOUR, RP_DAY, RP_WEEK, RP_MONTH, RP_YEAR
  } ftal_rtp_t;
  typedef enum logic [1:0] {S_IDLE, S_FHDR, S_FSLOT, S_TFLD} ftal_state_t;

endpackage
